// ===== bench/mocs_meter.sv
// Pulse counting meter that reports the half period of a square wave in clock cycles.
`timescale 1ns/1ps
module mocs_meter (
  input wire logic sys_clk_in,
  input wire logic sig_in,
  output logic [31:0] half_out
);
  logic prev_r = 1'b0;
  logic [31:0] cnt_r = 32'h0;
  // A steady level never updates the reading, so a stopped train keeps its last value.
  always @(posedge sys_clk_in) begin
    prev_r <= sig_in;
    cnt_r <= (sig_in != prev_r) ? 32'h1 : cnt_r + 32'h1;
    if (sig_in != prev_r) begin
      half_out <= cnt_r;
    end
  end
endmodule

// ===== bench/mocs_top_test.sv
// Self-checking bench for the monitor output and carrier select block.
`timescale 1ns/1ps
module mocs_top_test;
  import mocs_pkg::*;
  localparam int CHZ = 1000000;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hf;
  logic [31:0] wd = 32'h0;
  logic [31:0] q;
  logic [15:0] qv [0:7] = '{default: 16'h0};
  logic [31:0] rdata;
  logic wait_w;
  logic pul_w;
  logic car_w;
  logic [15:0] mv_w;
  logic [31:0] ph_w;
  logic [31:0] ch_w;
  logic [31:0] seed = 32'h957d699c;
  int n_mismatch = 0;
  int n_checks = 0;
  int pc [13] = '{0, 1, 6, 12, 24, 36, 40, 41, 42, 43, 44, 45, 50};
  int kt [6] = '{0, 1, 6, 12, 24, 36};
  int ct [8] = '{1, 2, 3, 4, 12, 7, 8, 9};
  longint dhz [5] = '{25000, 50000, 75000, 100000, 140000};
  longint g;
  longint mx;
  longint v;
  longint e;
  int nh;

  always #2 sys_clk_in = ~sys_clk_in;

  mocs_top #(.CLK_HZ(CHZ)) uut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_w),
    .out_freq_in(qv[0]), .out_current_in(qv[1]), .dc_bus_in(qv[2]), .torque_in(qv[3]),
    .out_power_in(qv[4]), .volt_ref_in(qv[5]), .freq_ref_in(qv[6]), .pid_fb_in(qv[7]),
    .monitor_output_terminal_mv_out(mv_w), .monitor_output_terminal_pulse_out(pul_w),
    .carrier_out(car_w)
  );
  mocs_meter pm (.sys_clk_in(sys_clk_in), .sig_in(pul_w), .half_out(ph_w));
  mocs_meter cm (.sys_clk_in(sys_clk_in), .sig_in(car_w), .half_out(ch_w));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] ctl(int t, int s, int sc, int c);
    return 32'((c << 16) | (sc << 8) | (s << 4) | t);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; holds the request until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (wait_w !== 1'b0 && n < 100);
    if (n >= 100) begin
      n_mismatch++;
      $display("ERROR %0t bus access timed out", $time);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic settle();
    repeat (400) @(posedge sys_clk_in);
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk_in);
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    repeat (8) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    bus(1'b0, OFF_CTRL, 32'h0);
    chk(q, 32'h00040000);
    bus(1'b0, OFF_GAIN, 32'h0);
    chk(q, 32'd100);
    // Analog path: every source, default gain first and then random gains.
    for (int s = 0; s < 9; s++) begin
      g = (s < 2) ? 100 : 50 + rnd() % 200;
      for (int i = 0; i < 8; i++) begin
        qv[i] <= 16'(1 + rnd() % 5999);
      end
      bus(1'b1, OFF_GAIN, 32'(g));
      bus(1'b1, OFF_COMM_ANA, rnd() % 1000);
      v = (s < 8) ? qv[s] : wd;
      bus(1'b1, OFF_CTRL, ctl(0, s, 50, 4));
      settle();
      e = (s == 0 || s == 6 || s == 7) ? v * g * 100 / 6000 : (s == 8) ? v * g / 10 : v * g / 100;
      bus(1'b0, OFF_STATUS, 32'h0);
      chk(q, 32'(e));
      chk({16'h0, mv_w}, 32'(e));
      nh = 0;
      repeat (100) begin
        @(posedge sys_clk_in);
        nh += (pul_w !== 1'b0);
      end
      chk(32'(nh), 32'h0);
    end
    // Pulse path: every scaling code against a random maximum frequency.
    mx = 3000 + rnd() % 6000;
    bus(1'b1, OFF_MAXF, 32'(mx));
    bus(1'b1, OFF_COMM_PUL, 32'd5000);
    for (int i = 0; i < 13; i++) begin
      qv[0] <= 16'(1000 + rnd() % 5000);
      qv[6] <= 16'(1000 + rnd() % 5000);
      bus(1'b1, OFF_CTRL, ctl(1, 0, pc[i], 4));
      settle();
      v = (i < 6) ? qv[0] : qv[6];
      e = (i == 12) ? (CHZ / 2) / 5000 : (kt[i % 6] == 0) ? CHZ * mx / (2880 * v) :
          CHZ * 50 / (kt[i % 6] * v);
      bus(1'b0, OFF_PUL_HALF, 32'h0);
      chk(q, 32'(e));
      chk({16'h0, mv_w}, 32'h0);
    end
    chk(ph_w, 32'd100);
    bus(1'b1, OFF_COMM_PUL, 32'd20000);
    bus(1'b0, OFF_COMM_PUL, 32'h0);
    chk(q, 32'd14400);
    // Byte lane 1 alone replaces only the upper byte of the gain.
    be <= 4'h2;
    bus(1'b1, OFF_GAIN, 32'h00001200);
    be <= 4'hf;
    bus(1'b0, OFF_GAIN, 32'h0);
    chk(q, 32'h00001200 | 32'(g & 8'hff));
    // Carrier: fixed and output-synchronous codes.
    // No serial host talks here; each carrier half period is read back over the Avalon-MM bus.
    qv[0] <= 16'(1000 + rnd() % 5000);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, OFF_CTRL, ctl(0, 0, 0, ct[i]));
      settle();
      e = (i < 5) ? CHZ * 5 / dhz[i] : CHZ * 50 / (12 * (1 << (i - 5)) * qv[0]);
      if (i == 7) begin
        e = CHZ * 50 / (36 * qv[0]);
      end
      bus(1'b0, OFF_CAR_HALF, 32'h0);
      chk(q, 32'(e));
      if (i == 0) begin
        chk(ch_w, 32'd200);
      end
    end
    // An unlisted carrier code leaves the last valid selection in place.
    bus(1'b1, OFF_CTRL, ctl(0, 0, 0, 5));
    bus(1'b0, OFF_CTRL, 32'h0);
    chk(q, 32'h00090000);
    close_out();
  end
endmodule

// ===== src/mocs_divider.sv
// Sequential restoring divider shared by all rate and level computations.
`timescale 1ns/1ps
module mocs_divider #(
  parameter int NW = 48,
  parameter int DW = 32
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic [NW-1:0] num_in,
  input wire logic [DW-1:0] den_in,
  output logic done_out,
  output logic [NW-1:0] quot_out
);
  localparam int CW = $clog2(NW + 1);
  localparam int DONE_LAG = NW + 1;
  logic busy_r, busy_nxt, done_r, done_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [NW-1:0] quo_r, quo_nxt;
  logic [DW:0] rem_r, rem_nxt, sh;
  logic [DW-1:0] den_r, den_nxt;

  // One quotient bit per cycle keeps the area small; rates change slowly anyway.
  always_comb begin
    busy_nxt = busy_r;
    cnt_nxt = cnt_r;
    quo_nxt = quo_r;
    rem_nxt = rem_r;
    den_nxt = den_r;
    done_nxt = 1'b0;
    sh = {rem_r[DW-1:0], quo_r[NW-1]};
    if (!busy_r && start_in) begin
      busy_nxt = 1'b1;
      cnt_nxt = CW'(NW);
      quo_nxt = num_in;
      rem_nxt = '0;
      den_nxt = den_in;
    end else if (busy_r) begin
      if (sh >= {1'b0, den_r}) begin
        rem_nxt = sh - {1'b0, den_r};
        quo_nxt = {quo_r[NW-2:0], 1'b1};
      end else begin
        rem_nxt = sh;
        quo_nxt = {quo_r[NW-2:0], 1'b0};
      end
      cnt_nxt = cnt_r - CW'(1);
      if (cnt_r == CW'(1)) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= '0;
      quo_r <= '0;
      rem_r <= '0;
      den_r <= '0;
    end else begin
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      cnt_r <= cnt_nxt;
      quo_r <= quo_nxt;
      rem_r <= rem_nxt;
      den_r <= den_nxt;
    end
  end

  assign done_out = done_r;
  assign quot_out = quo_r;

  div_latency_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (start_in && !busy_r) |-> ##DONE_LAG done_out)
    else $error("Divider result not ready after the fixed latency.");
endmodule

// ===== src/mocs_pkg.sv
// Shared constants and types for the monitor output and carrier select block.
package mocs_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_HZ_DEF = 1000000000 / CLK_PERIOD_NS;
  localparam int NUM_W = 48;
  localparam int DEN_W = 32;
  localparam int AW = 5;

  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_GAIN = 5'h04;
  localparam logic [4:0] OFF_MAXF = 5'h08;
  localparam logic [4:0] OFF_COMM_ANA = 5'h0c;
  localparam logic [4:0] OFF_COMM_PUL = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h14;
  localparam logic [4:0] OFF_PUL_HALF = 5'h18;
  localparam logic [4:0] OFF_CAR_HALF = 5'h1c;

  localparam int CTRL_TYPE_BIT = 0;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CTRL_SCALE_LSB = 8;
  localparam int CTRL_CAR_LSB = 16;
  localparam int STAT_TYPE_BIT = 16;

  localparam logic MON_ANALOG = 1'b0;
  localparam logic MON_PULSE = 1'b1;

  localparam logic [3:0] SRC_FOUT = 4'h0;
  localparam logic [3:0] SRC_CUR = 4'h1;
  localparam logic [3:0] SRC_DCV = 4'h2;
  localparam logic [3:0] SRC_TRQ = 4'h3;
  localparam logic [3:0] SRC_PWR = 4'h4;
  localparam logic [3:0] SRC_VREF = 4'h5;
  localparam logic [3:0] SRC_FREF = 4'h6;
  localparam logic [3:0] SRC_PID = 4'h7;
  localparam logic [3:0] SRC_COMM = 4'h8;

  localparam logic [5:0] SCALE_1440_FOUT = 6'h00;
  localparam logic [5:0] SCALE_1440_FREF = 6'h28;
  localparam logic [5:0] SCALE_COMM = 6'h32;
  localparam logic [15:0] PULSE_COMM_MAX = 16'h3840;
  localparam int PULSE_FULL_HZ = 1440;

  localparam logic [15:0] GAIN_DEF = 16'h0064;
  localparam logic [15:0] MAXF_DEF = 16'h1770;
  localparam int GAIN_ONE = 100;
  localparam int FULL_MV = 10000;
  localparam int PCT_FULL = 10000;
  localparam int COMM_ANA_FULL = 1000;
  localparam int CHZ_PER_HZ = 100;

  localparam logic [3:0] CAR_2K5 = 4'h1;
  localparam logic [3:0] CAR_5K = 4'h2;
  localparam logic [3:0] CAR_7K5 = 4'h3;
  localparam logic [3:0] CAR_10K = 4'h4;
  localparam logic [3:0] CAR_14K = 4'hc;
  localparam logic [3:0] CAR_SYNC12 = 4'h7;
  localparam logic [3:0] CAR_SYNC24 = 4'h8;
  localparam logic [3:0] CAR_SYNC36 = 4'h9;
  localparam logic [3:0] CAR_DEF_SEL = 4'h4;
  localparam logic [17:0] CAR_DHZ_2K5 = 18'h061a8;
  localparam logic [17:0] CAR_DHZ_5K = 18'h0c350;
  localparam logic [17:0] CAR_DHZ_7K5 = 18'h124f8;
  localparam logic [17:0] CAR_DHZ_10K = 18'h186a0;
  localparam logic [17:0] CAR_DHZ_14K = 18'h222e0;
  localparam int DHZ_PER_HZ = 10;

  localparam logic [1:0] JOB_ANA = 2'h0;
  localparam logic [1:0] JOB_PUL = 2'h1;
  localparam logic [1:0] JOB_CAR = 2'h2;

  typedef enum logic [1:0] {
    ST_GO = 2'b01,
    ST_WAIT = 2'b10
  } mocs_state_t;
endpackage

// ===== src/mocs_top.sv
// Monitor output selection, pulse train monitor and carrier generator with register slave.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - Analog monitor follows selected quantity, codes 0-6.
// - Code 7: PID feedback, max frequency is 10 V.
// - Code 8: communications value, 1000 counts 10 V.
// - Analog selection acts only in analog type.
// - Default gain gives 10 V at 100 percent.
// - Full scale 10 V times gain setting.
// - Output type: 0 analog, 1 pulse, reset 0.
// - Pulse codes 0,1,6,12,24,36 track output frequency.
// - Codes 40-45 same scalings from frequency reference.
// - Code 50: written value, 1 Hz per count, 14400 max.
// - Pulse selection acts only in pulse type.
// - Fixed carriers 2.5, 5, 7.5, 10, 14 kHz.
// - Carrier codes 7-9 track output frequency 12/24/36x.
// - Carrier reset value depends on unit capacity.
module mocs_top #(
  parameter int CLK_HZ = mocs_pkg::CLK_HZ_DEF,
  parameter logic [3:0] CARRIER_DEFAULT = mocs_pkg::CAR_DEF_SEL
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [mocs_pkg::AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [15:0] out_freq_in,
  input wire logic [15:0] freq_ref_in,
  input wire logic [15:0] pid_fb_in,
  input wire logic [15:0] out_current_in,
  input wire logic [15:0] dc_bus_in,
  input wire logic [15:0] torque_in,
  input wire logic [15:0] out_power_in,
  input wire logic [15:0] volt_ref_in,
  output logic [15:0] monitor_output_terminal_mv_out,
  output logic monitor_output_terminal_pulse_out,
  output logic carrier_out
);
  import mocs_pkg::*;

  if (CLK_HZ < 1000 || CLK_HZ > 1000000000) begin : g_bad_clk
    $error("CLK_HZ outside the range the rate arithmetic supports.");
  end

  function automatic logic [5:0] scale_mult(input logic [5:0] c);
    case (c)
      6'h01, 6'h29: scale_mult = 6'h01;
      6'h06, 6'h2a: scale_mult = 6'h06;
      6'h0c, 6'h2b: scale_mult = 6'h0c;
      6'h18, 6'h2c: scale_mult = 6'h18;
      6'h24, 6'h2d: scale_mult = 6'h24;
      default: scale_mult = 6'h00;
    endcase
  endfunction

  function automatic logic [5:0] car_mult(input logic [3:0] c);
    case (c)
      CAR_SYNC12: car_mult = 6'h0c;
      CAR_SYNC24: car_mult = 6'h18;
      CAR_SYNC36: car_mult = 6'h24;
      default: car_mult = 6'h00;
    endcase
  endfunction

  function automatic logic [17:0] car_dhz(input logic [3:0] c);
    case (c)
      CAR_2K5: car_dhz = CAR_DHZ_2K5;
      CAR_5K: car_dhz = CAR_DHZ_5K;
      CAR_7K5: car_dhz = CAR_DHZ_7K5;
      CAR_10K: car_dhz = CAR_DHZ_10K;
      CAR_14K: car_dhz = CAR_DHZ_14K;
      default: car_dhz = 18'h00000;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  function automatic logic [31:0] sat32(input logic [NUM_W-1:0] q);
    sat32 = (|q[NUM_W-1:32]) ? 32'hffffffff : q[31:0];
  endfunction

  logic mon_type_r, mon_type_nxt;
  logic [3:0] src_r, src_nxt, car_r, car_nxt;
  logic [5:0] scale_r, scale_nxt;
  logic [15:0] gain_r, gain_nxt, maxf_r, maxf_nxt;
  logic [15:0] comm_ana_r, comm_ana_nxt, comm_pul_r, comm_pul_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt, ctrl_word, rd_mux, w;
  logic [31:0] pul_half_r, pul_half_nxt, car_half_r, car_half_nxt, res;
  logic req;

  assign ctrl_word = {12'h000, car_r, 2'h0, scale_r, src_r, 3'h0, mon_type_r};
  assign req = avs_read_in | avs_write_in;

  always_comb begin
    case (avs_address_in)
      OFF_CTRL: rd_mux = ctrl_word;
      OFF_GAIN: rd_mux = {16'h0000, gain_r};
      OFF_MAXF: rd_mux = {16'h0000, maxf_r};
      OFF_COMM_ANA: rd_mux = {16'h0000, comm_ana_r};
      OFF_COMM_PUL: rd_mux = {16'h0000, comm_pul_r};
      OFF_STATUS: rd_mux = {15'h0000, mon_type_r, monitor_output_terminal_mv_out};
      OFF_PUL_HALF: rd_mux = pul_half_r;
      OFF_CAR_HALF: rd_mux = car_half_r;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Each access waits one cycle, so the read mux sees settled inputs.
  always_comb begin
    mon_type_nxt = mon_type_r;
    src_nxt = src_r;
    scale_nxt = scale_r;
    car_nxt = car_r;
    gain_nxt = gain_r;
    maxf_nxt = maxf_r;
    comm_ana_nxt = comm_ana_r;
    comm_pul_nxt = comm_pul_r;
    rdata_nxt = rdata_r;
    wait_nxt = 1'b1;
    w = 32'h00000000;
    if (req && wait_r) begin
      wait_nxt = 1'b0;
      if (avs_read_in) begin
        rdata_nxt = rd_mux;
      end
      if (avs_write_in) begin
        case (avs_address_in)
          OFF_CTRL: begin
            w = merge(ctrl_word, avs_writedata_in, avs_byteenable_in);
            mon_type_nxt = w[CTRL_TYPE_BIT];
            if (w[CTRL_SRC_LSB +: 4] <= SRC_COMM) begin
              src_nxt = w[CTRL_SRC_LSB +: 4];
            end
            if (w[CTRL_SCALE_LSB +: 6] == SCALE_1440_FOUT || w[CTRL_SCALE_LSB +: 6] ==
                SCALE_1440_FREF || w[CTRL_SCALE_LSB +: 6] == SCALE_COMM ||
                scale_mult(w[CTRL_SCALE_LSB +: 6]) != 6'h00) begin
              scale_nxt = w[CTRL_SCALE_LSB +: 6];
            end
            if (car_dhz(w[CTRL_CAR_LSB +: 4]) != 18'h00000 ||
                car_mult(w[CTRL_CAR_LSB +: 4]) != 6'h00) begin
              car_nxt = w[CTRL_CAR_LSB +: 4];
            end
          end
          OFF_GAIN: begin
            w = merge({16'h0000, gain_r}, avs_writedata_in, avs_byteenable_in);
            gain_nxt = w[15:0];
          end
          OFF_MAXF: begin
            w = merge({16'h0000, maxf_r}, avs_writedata_in, avs_byteenable_in);
            maxf_nxt = w[15:0];
          end
          OFF_COMM_ANA: begin
            w = merge({16'h0000, comm_ana_r}, avs_writedata_in, avs_byteenable_in);
            comm_ana_nxt = w[15:0];
          end
          OFF_COMM_PUL: begin
            w = merge({16'h0000, comm_pul_r}, avs_writedata_in, avs_byteenable_in);
            comm_pul_nxt = (w[15:0] > PULSE_COMM_MAX) ? PULSE_COMM_MAX : w[15:0];
          end
          default: w = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      mon_type_r <= MON_ANALOG;
      src_r <= SRC_FOUT;
      scale_r <= SCALE_1440_FOUT;
      car_r <= CARRIER_DEFAULT;
      gain_r <= GAIN_DEF;
      maxf_r <= MAXF_DEF;
      comm_ana_r <= 16'h0000;
      comm_pul_r <= 16'h0000;
      rdata_r <= 32'h00000000;
      wait_r <= 1'b1;
    end else begin
      mon_type_r <= mon_type_nxt;
      src_r <= src_nxt;
      scale_r <= scale_nxt;
      car_r <= car_nxt;
      gain_r <= gain_nxt;
      maxf_r <= maxf_nxt;
      comm_ana_r <= comm_ana_nxt;
      comm_pul_r <= comm_pul_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
    end
  end

  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = wait_r;

  mocs_state_t st_r, st_nxt;
  logic [1:0] job_r, job_nxt;
  logic [NUM_W-1:0] job_num, div_quot;
  logic [DEN_W-1:0] job_den;
  logic [15:0] qsel, afreq, pfreq, ana_val_r, ana_nxt;
  logic div_start, div_done;

  // Every quotient is a level in mV or a half period in clock cycles.
  always_comb begin
    job_num = '0;
    job_den = '0;
    afreq = (src_r == SRC_FREF) ? freq_ref_in : ((src_r == SRC_PID) ? pid_fb_in : out_freq_in);
    pfreq = (scale_r >= SCALE_1440_FREF) ? freq_ref_in : out_freq_in;
    case (src_r)
      SRC_CUR: qsel = out_current_in;
      SRC_DCV: qsel = dc_bus_in;
      SRC_TRQ: qsel = torque_in;
      SRC_PWR: qsel = out_power_in;
      SRC_VREF: qsel = volt_ref_in;
      SRC_COMM: qsel = comm_ana_r;
      default: qsel = 16'h0000;
    endcase
    case (job_r)
      JOB_ANA: begin
        if (src_r == SRC_FOUT || src_r == SRC_FREF || src_r == SRC_PID) begin
          job_num = NUM_W'(afreq) * NUM_W'(gain_r) * NUM_W'(FULL_MV / GAIN_ONE);
          job_den = DEN_W'(maxf_r);
        end else if (src_r == SRC_COMM) begin
          job_num = NUM_W'(qsel) * NUM_W'(gain_r) * NUM_W'(FULL_MV);
          job_den = DEN_W'(COMM_ANA_FULL * GAIN_ONE);
        end else begin
          job_num = NUM_W'(qsel) * NUM_W'(gain_r) * NUM_W'(FULL_MV);
          job_den = DEN_W'(PCT_FULL * GAIN_ONE);
        end
      end
      JOB_PUL: begin
        if (scale_r == SCALE_COMM) begin
          job_num = NUM_W'(CLK_HZ / 2);
          job_den = DEN_W'(comm_pul_r);
        end else if (scale_mult(scale_r) == 6'h00) begin
          job_num = NUM_W'(CLK_HZ) * NUM_W'(maxf_r);
          job_den = DEN_W'(2 * PULSE_FULL_HZ) * DEN_W'(pfreq);
        end else begin
          job_num = NUM_W'(CLK_HZ) * NUM_W'(CHZ_PER_HZ / 2);
          job_den = DEN_W'(scale_mult(scale_r)) * DEN_W'(pfreq);
        end
      end
      JOB_CAR: begin
        if (car_mult(car_r) != 6'h00) begin
          job_num = NUM_W'(CLK_HZ) * NUM_W'(CHZ_PER_HZ / 2);
          job_den = DEN_W'(car_mult(car_r)) * DEN_W'(out_freq_in);
        end else begin
          job_num = NUM_W'(CLK_HZ) * NUM_W'(DHZ_PER_HZ / 2);
          job_den = DEN_W'(car_dhz(car_r));
        end
      end
      default: job_den = '0;
    endcase
  end

  // Jobs run round robin, so any change of source or scaling is picked up.
  always_comb begin
    st_nxt = st_r;
    job_nxt = job_r;
    div_start = 1'b0;
    ana_nxt = ana_val_r;
    pul_half_nxt = pul_half_r;
    car_half_nxt = car_half_r;
    res = 32'h00000000;
    case (st_r)
      ST_GO: begin
        if (job_den == '0) begin
          job_nxt = (job_r == JOB_CAR) ? JOB_ANA : job_r + 2'h1;
        end else begin
          div_start = 1'b1;
          st_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (div_done) begin
          res = sat32(div_quot);
          st_nxt = ST_GO;
          job_nxt = (job_r == JOB_CAR) ? JOB_ANA : job_r + 2'h1;
        end
      end
      default: st_nxt = ST_GO;
    endcase
    // A result lands only when a divide ends or a job is skipped, so outputs never blink.
    if ((st_r == ST_WAIT && !div_done) || (st_r == ST_GO && job_den != '0)) begin
      res = 32'h00000000;
    end else if (job_r == JOB_ANA) begin
      ana_nxt = (|res[31:16]) ? 16'hffff : res[15:0];
    end else if (job_r == JOB_PUL) begin
      pul_half_nxt = res;
    end else begin
      car_half_nxt = res;
    end
  end

  mocs_divider #(
    .NW(NUM_W),
    .DW(DEN_W)
  ) u_div (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .start_in(div_start),
    .num_in(job_num),
    .den_in(job_den),
    .done_out(div_done),
    .quot_out(div_quot)
  );

  logic [31:0] pul_cnt_r, pul_cnt_nxt, car_cnt_r, car_cnt_nxt;
  logic [15:0] mv_nxt;
  logic pulse_nxt, car_out_nxt, pul_act, pul_wrap;

  assign pul_act = (mon_type_r == MON_PULSE) && (pul_half_r != 32'h00000000);
  assign pul_wrap = pul_cnt_r >= pul_half_r - 32'h00000001;

  // A shrinking half period takes effect at once because the compare is >=.
  always_comb begin
    mv_nxt = (mon_type_r == MON_ANALOG) ? ana_val_r : 16'h0000;
    pulse_nxt = monitor_output_terminal_pulse_out;
    pul_cnt_nxt = pul_cnt_r + 32'h00000001;
    if (!pul_act) begin
      pulse_nxt = 1'b0;
      pul_cnt_nxt = 32'h00000000;
    end else if (pul_wrap) begin
      pulse_nxt = !monitor_output_terminal_pulse_out;
      pul_cnt_nxt = 32'h00000000;
    end
    car_out_nxt = carrier_out;
    car_cnt_nxt = car_cnt_r + 32'h00000001;
    if (car_half_r == 32'h00000000) begin
      car_out_nxt = 1'b0;
      car_cnt_nxt = 32'h00000000;
    end else if (car_cnt_r >= car_half_r - 32'h00000001) begin
      car_out_nxt = !carrier_out;
      car_cnt_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      st_r <= ST_GO;
      job_r <= JOB_ANA;
      ana_val_r <= 16'h0000;
      pul_half_r <= 32'h00000000;
      car_half_r <= 32'h00000000;
      pul_cnt_r <= 32'h00000000;
      car_cnt_r <= 32'h00000000;
      monitor_output_terminal_mv_out <= 16'h0000;
      monitor_output_terminal_pulse_out <= 1'b0;
      carrier_out <= 1'b0;
    end else begin
      st_r <= st_nxt;
      job_r <= job_nxt;
      ana_val_r <= ana_nxt;
      pul_half_r <= pul_half_nxt;
      car_half_r <= car_half_nxt;
      pul_cnt_r <= pul_cnt_nxt;
      car_cnt_r <= car_cnt_nxt;
      monitor_output_terminal_mv_out <= mv_nxt;
      monitor_output_terminal_pulse_out <= pulse_nxt;
      carrier_out <= car_out_nxt;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  logic wr_ctrl;
  assign wr_ctrl = avs_write_in && wait_r && avs_address_in == OFF_CTRL && avs_byteenable_in[0];

  bus_wait_a: assert property (req && wait_r |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("Wait request did not drop for exactly one cycle.");
  analog_gated_a: assert property (mon_type_r == MON_PULSE |=>
    monitor_output_terminal_mv_out == 0)
    else $error("Analog level present in pulse mode.");
  pulse_gated_a: assert property (mon_type_r == MON_ANALOG |=>
    !monitor_output_terminal_pulse_out)
    else $error("Pulse output active in analog mode.");
  type_write_a: assert property (wr_ctrl |=> mon_type_r == $past(avs_writedata_in[0]))
    else $error("Output type not taken from the write.");
  src_keep_a: assert property (wr_ctrl && avs_writedata_in[7:4] > SRC_COMM |=>
    $stable(src_r))
    else $error("Invalid source code was accepted.");
  gain_reset_a: assert property ($rose(resetn_in) |-> gain_r == GAIN_DEF)
    else $error("Gain not at its default after reset.");
  car_reset_a: assert property ($rose(resetn_in) |-> car_r == CARRIER_DEFAULT)
    else $error("Carrier selection not at its default after reset.");
  pul_clamp_a: assert property (comm_pul_r <= PULSE_COMM_MAX)
    else $error("Communications pulse rate above its limit.");
  car_fixed_a: assert property (st_r == ST_WAIT && job_r == JOB_CAR && div_done &&
    $past(car_r, NUM_W + 1) == CAR_2K5 |=> car_half_r == 32'((CLK_HZ * 5) / CAR_DHZ_2K5))
    else $error("Wrong half period for the lowest fixed carrier.");
  pul_toggle_a: assert property (pul_act && pul_wrap |=>
    monitor_output_terminal_pulse_out != $past(monitor_output_terminal_pulse_out))
    else $error("Pulse output missed its toggle.");

  pulse_run_c: cover property (pul_act ##1 $rose(monitor_output_terminal_pulse_out));
  carrier_run_c: cover property ($rose(carrier_out));
  read_c: cover property (avs_read_in && !avs_waitrequest_out);
  analog_c: cover property (monitor_output_terminal_mv_out != 16'h0000);
endmodule
